// file: hdl/wdps_pkg.sv
// Package of constants and types for the watchdog period selection block.
package wdps_pkg;

    // ------------------------------------------------------------------
    // Configuration field layout and codes
    // ------------------------------------------------------------------
    localparam int PS_W = 5;
    localparam int CS_W = 3;
    localparam int MODE_W = 2;
    localparam logic [PS_W-1:0] PS_ERASED = 5'h1f;
    localparam logic [PS_W-1:0] PS_SW_DEFAULT = 5'h0b;
    localparam logic [PS_W-1:0] PS_MIN_CODE = 5'h13;
    localparam logic [PS_W-1:0] PS_MAX_RATIO = 5'h12;
    localparam logic [CS_W-1:0] CS_ERASED = 3'h7;
    localparam logic [CS_W-1:0] CS_LFINT = 3'h0;
    localparam logic [CS_W-1:0] CS_MFINT = 3'h1;
    localparam logic [CS_W-1:0] CS_SOSC = 3'h2;
    localparam logic [CS_W-1:0] CS_SOFT = 3'h7;
    localparam logic [MODE_W-1:0] MODE_ERASED = 2'h3;
    localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
    localparam logic [MODE_W-1:0] MODE_SOFT = 2'h1;
    localparam logic [MODE_W-1:0] MODE_AWAKE = 2'h2;
    localparam logic [MODE_W-1:0] MODE_ON = 2'h3;

    // ------------------------------------------------------------------
    // Prescaler: divider is 2^(5+code), counter holds up to 2^23-1
    // ------------------------------------------------------------------
    localparam int CNT_W = 23;
    localparam logic [PS_W-1:0] PS_TOP_IDX = 5'h12;
    localparam logic [1:0] LOAD_WAIT = 2'h2;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_KICK = 8'h08;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PS_LSB = 1;
    localparam int CTRL_CS_LSB = 6;
    localparam int IRQ_W = 2;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_REFUSED = 1;
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    // Load sequence of the configuration capture.
    typedef enum logic [1:0] {WDPS_WAIT, WDPS_RUN} wdps_state_t;

endpackage : wdps_pkg

// file: hdl/wdps_top.sv
// Watchdog period selection, clock and mode decode, prescaler and registers.
//
// Summary of operation
// R01: A 5-bit configuration field selects the watchdog prescaler divide ratio.
// R02: Codes 00000..10010 load unchanged at reset; divider 2^(5+code), locked.
// R03: Code 11111 loads 01011 (1:65536) and lets software rewrite the period.
// R04: Blank configuration reads all ones, giving the software-controlled default.
// R05: Code 10011 copies unchanged, gives divider 1:32, no software control.
// R06: Undocumented codes 10100..11110 act as minimum divider without software control.
// R07: Clock source 000 counts the low-frequency internal oscillator ticks.
// R08: Mode 11 always runs, 00 disabled, 01 follows the software enable.
//
// Our own choices: the Wishbone register port and the register addresses.
module wdps_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] period_select_cfg_i,
    input wire logic [2:0] clock_source_cfg_i,
    input wire logic [1:0] operating_mode_cfg_i,
    input wire logic low_freq_internal_osc_i,
    input wire logic mid_freq_internal_osc_i,
    input wire logic secondary_osc_i,
    input wire logic sleep_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic irq_o,
    output logic wdog_timeout_o,
    output logic [4:0] period_select_run_o
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------

    // Configuration and oscillator pins come from other domains.
    // R04 erased value
    logic [9:0] cfg_s1_ff;
    logic [9:0] cfg_s2_ff;
    logic [3:0] osc_s1_ff;
    logic [3:0] osc_s2_ff;
    logic [2:0] osc_d_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_s1_ff <= {wdps_pkg::PS_ERASED, wdps_pkg::CS_ERASED, wdps_pkg::MODE_ERASED};
            cfg_s2_ff <= {wdps_pkg::PS_ERASED, wdps_pkg::CS_ERASED, wdps_pkg::MODE_ERASED};
            osc_s1_ff <= 4'h0;
            osc_s2_ff <= 4'h0;
            osc_d_ff <= 3'h0;
        end else begin
            cfg_s1_ff <= {period_select_cfg_i, clock_source_cfg_i, operating_mode_cfg_i};
            cfg_s2_ff <= cfg_s1_ff;
            osc_s1_ff <= {sleep_i, secondary_osc_i, mid_freq_internal_osc_i,
                          low_freq_internal_osc_i};
            osc_s2_ff <= osc_s1_ff;
            osc_d_ff <= osc_s2_ff[2:0];
        end
    end

    logic [4:0] cfg_ps;
    logic [2:0] cfg_cs;
    logic [1:0] cfg_mode;
    logic sleep_s;
    logic [2:0] osc_rise;
    assign cfg_ps = cfg_s2_ff[9:5];
    assign cfg_cs = cfg_s2_ff[4:2];
    assign cfg_mode = cfg_s2_ff[1:0];
    assign sleep_s = osc_s2_ff[3];
    assign osc_rise = osc_s2_ff[2:0] & ~osc_d_ff;

    // ------------------------------------------------------------------
    // Power-on capture of the period selection
    // ------------------------------------------------------------------

    // The field is taken only once the synchronisers hold settled data,
    // so a reset release never captures a half-updated code.
    wdps_pkg::wdps_state_t state_ff;
    wdps_pkg::wdps_state_t nxt_state;
    logic [1:0] wait_ff;
    logic [1:0] nxt_wait;
    logic [4:0] ps_run_ff;
    logic [4:0] nxt_ps_run;
    logic sw_ps_ff;
    logic nxt_sw_ps;
    logic [2:0] cs_ff;
    logic [2:0] nxt_cs;
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;
    logic ps_wr;
    logic [4:0] ps_wr_val;

    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_ps_run = ps_run_ff;
        nxt_sw_ps = sw_ps_ff;
        nxt_cs = cs_ff;
        nxt_mode = mode_ff;
        case (state_ff)
            wdps_pkg::WDPS_WAIT: begin
                nxt_wait = wait_ff + 2'h1;
                if (wait_ff == wdps_pkg::LOAD_WAIT) begin
                    nxt_state = wdps_pkg::WDPS_RUN;
                    nxt_cs = cfg_cs;
                    nxt_mode = cfg_mode;
                    // R01 field decode
                    if (cfg_ps == wdps_pkg::PS_ERASED) begin
                        // R03 software default
                        nxt_ps_run = wdps_pkg::PS_SW_DEFAULT;
                        nxt_sw_ps = 1'b1;
                    end else if (cfg_ps <= wdps_pkg::PS_MAX_RATIO) begin
                        // R02 locked copy
                        nxt_ps_run = cfg_ps;
                        nxt_sw_ps = 1'b0;
                    end else begin
                        // R05 R06 minimum divider
                        nxt_ps_run = wdps_pkg::PS_MIN_CODE;
                        nxt_sw_ps = 1'b0;
                    end
                end
            end
            wdps_pkg::WDPS_RUN: begin
                // R03 software rewrite
                if (ps_wr && sw_ps_ff) begin
                    nxt_ps_run = ps_wr_val;
                end
            end
            default: begin
                nxt_state = wdps_pkg::WDPS_WAIT;
            end
        endcase
    end

    // R04 reset default
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= wdps_pkg::WDPS_WAIT;
            wait_ff <= 2'h0;
            ps_run_ff <= wdps_pkg::PS_SW_DEFAULT;
            sw_ps_ff <= 1'b1;
            cs_ff <= wdps_pkg::CS_ERASED;
            mode_ff <= wdps_pkg::MODE_ERASED;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            ps_run_ff <= nxt_ps_run;
            sw_ps_ff <= nxt_sw_ps;
            cs_ff <= nxt_cs;
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------------
    // Reference selection, run decision and prescaler
    // ------------------------------------------------------------------

    logic sw_en_ff;
    logic [2:0] sw_cs_ff;
    logic [2:0] eff_cs;
    logic tick;
    logic running;
    logic [4:0] ratio_idx;
    logic [22:0] limit;

    // Reserved source codes fall back to the low-frequency oscillator.
    always_comb begin
        eff_cs = (cs_ff == wdps_pkg::CS_SOFT) ? sw_cs_ff : cs_ff;
        case (eff_cs)
            // R07 low-frequency reference
            wdps_pkg::CS_LFINT: tick = osc_rise[0];
            wdps_pkg::CS_MFINT: tick = osc_rise[1];
            wdps_pkg::CS_SOSC: tick = osc_rise[2];
            default: tick = osc_rise[0];
        endcase
        // R08 operating mode
        case (mode_ff)
            wdps_pkg::MODE_ON: running = 1'b1;
            wdps_pkg::MODE_AWAKE: running = ~sleep_s;
            wdps_pkg::MODE_SOFT: running = sw_en_ff;
            default: running = 1'b0;
        endcase
        running = running && (state_ff == wdps_pkg::WDPS_RUN);
        // R05 minimum ratio
        ratio_idx = (ps_run_ff > wdps_pkg::PS_MAX_RATIO) ? 5'h00 : ps_run_ff;
        // R02 divider two to five plus code
        limit = {23{1'b1}} >> (wdps_pkg::PS_TOP_IDX - ratio_idx);
    end

    logic [22:0] cnt_ff;
    logic [22:0] nxt_cnt;
    logic timeout_ff;
    logic nxt_timeout;
    logic kick;

    // A kick or a stop restarts the whole period, never a partial one.
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_timeout = 1'b0;
        if (!running || kick) begin
            nxt_cnt = 23'h0;
        end else if (tick) begin
            if (cnt_ff >= limit) begin
                nxt_cnt = 23'h0;
                nxt_timeout = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 23'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 23'h0;
            timeout_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            timeout_ff <= nxt_timeout;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave and interrupt registers
    // ------------------------------------------------------------------

    logic req;
    logic wr;
    logic refused;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    logic nxt_sw_en;
    logic [2:0] nxt_sw_cs;
    logic [1:0] stat_ff;
    logic [1:0] nxt_stat;
    logic [1:0] mask_ff;
    logic [1:0] nxt_mask;
    logic irq_ff;
    logic [1:0] events;

    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req && wb_we_i;
    assign ps_wr = wr && (wb_adr_i == wdps_pkg::ADR_CTRL) && wb_sel_i[0];
    assign ps_wr_val = wb_dat_i[wdps_pkg::CTRL_PS_LSB +: 5];
    // R02 locked period refuses writes
    assign refused = ps_wr && !sw_ps_ff && (state_ff == wdps_pkg::WDPS_RUN);
    assign kick = wr && (wb_adr_i == wdps_pkg::ADR_KICK) && wb_sel_i[0] && wb_dat_i[0];
    assign events = {refused, timeout_ff};

    // Set beats clear so an event landing on its own clear is kept.
    always_comb begin
        nxt_sw_en = sw_en_ff;
        nxt_sw_cs = sw_cs_ff;
        nxt_stat = stat_ff;
        nxt_mask = mask_ff;
        nxt_dat = 32'h0;
        if (wr) begin
            case (wb_adr_i)
                wdps_pkg::ADR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        nxt_sw_en = wb_dat_i[wdps_pkg::CTRL_EN_BIT];
                    end
                    if (wb_sel_i[0] && wb_sel_i[1]) begin
                        nxt_sw_cs = wb_dat_i[wdps_pkg::CTRL_CS_LSB +: 3];
                    end
                end
                wdps_pkg::ADR_IRQ_STAT: begin
                    if (wb_sel_i[0]) begin
                        nxt_stat = stat_ff & ~wb_dat_i[1:0];
                    end
                end
                wdps_pkg::ADR_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        nxt_mask = wb_dat_i[1:0];
                    end
                end
                default: begin
                    nxt_mask = mask_ff;
                end
            endcase
        end else if (req) begin
            case (wb_adr_i)
                wdps_pkg::ADR_CTRL: begin
                    nxt_dat = {23'h0, sw_cs_ff, ps_run_ff, sw_en_ff};
                end
                wdps_pkg::ADR_STATUS: begin
                    nxt_dat = {20'h0, mode_ff, eff_cs, running, sw_ps_ff, ps_run_ff};
                end
                wdps_pkg::ADR_IRQ_STAT: begin
                    nxt_dat = {30'h0, stat_ff};
                end
                wdps_pkg::ADR_IRQ_MASK: begin
                    nxt_dat = {30'h0, mask_ff};
                end
                default: begin
                    nxt_dat = 32'h0;
                end
            endcase
        end
        nxt_stat = nxt_stat | events;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
            sw_en_ff <= wdps_pkg::CTRL_EN_RST;
            sw_cs_ff <= wdps_pkg::CS_LFINT;
            stat_ff <= 2'h0;
            mask_ff <= wdps_pkg::IRQ_MASK_RST;
            irq_ff <= 1'b0;
        end else begin
            ack_ff <= req;
            dat_ff <= nxt_dat;
            sw_en_ff <= nxt_sw_en;
            sw_cs_ff <= nxt_sw_cs;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff <= |(nxt_stat & nxt_mask);
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign irq_o = irq_ff;
    assign wdog_timeout_o = timeout_ff;
    assign period_select_run_o = ps_run_ff;

endmodule // wdps_top

// file: test/wdps_top_asserts.sv
// Port checker of the watchdog period selection block.
module wdps_top_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] period_select_cfg_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic irq_o,
    input wire logic wdog_timeout_o,
    input wire logic [4:0] period_select_run_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking

    // Undocumented codes fall back to the locked minimum divider.
    logic [4:0] exp_run;
    assign exp_run = (period_select_cfg_i <= 5'h12) ? period_select_cfg_i :
        ((period_select_cfg_i == 5'h1f) ? 5'h0b : 5'h13);

    a_rst_default: assert property (rst_i |=> period_select_run_o == 5'h0b)
        else $error("run code not at default in reset");
    a_capture_code: assert property (disable iff (rst_i)
        $fell(rst_i) |-> ##3 period_select_run_o == exp_run)
        else $error("run code wrong after capture");
    a_reset_quiet: assert property (rst_i |=> !irq_o && !wdog_timeout_o && !wb_ack_o)
        else $error("outputs active in reset");
    a_ack_follows: assert property (disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_single: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (disable iff (rst_i)
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_data_idle: assert property (disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_write_data: assert property (disable iff (rst_i)
        wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
        else $error("read data on write");
    a_timeout_pulse: assert property (disable iff (rst_i)
        wdog_timeout_o |=> !wdog_timeout_o)
        else $error("timeout longer than one cycle");

    c_write: cover property (wb_ack_o && wb_we_i);
    c_irq: cover property ($rose(irq_o));
    c_timeout: cover property (wdog_timeout_o);
endmodule // wdps_top_asserts

bind wdps_top wdps_top_asserts u_asserts (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .period_select_cfg_i(period_select_cfg_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .irq_o(irq_o),
    .wdog_timeout_o(wdog_timeout_o),
    .period_select_run_o(period_select_run_o)
);

// file: test/wdps_top_test.sv
// Self-checking bench of the watchdog period selection block.
module wdps_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] cfg_ps = 5'h1f;
    logic [1:0] cfg_mode = 2'h3;
    logic lf_osc = 1'b0;
    logic sleep = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic tmo;
    logic [4:0] run;
    logic [2:0] osc_div = 3'h0;
    logic [31:0] q;
    int error_cnt = 0;
    int num_checks = 0;
    int n;

    always #4 clk_i = ~clk_i;

    // Reference at one eighth of the bus clock, well below the clk/2 limit.
    always @(posedge clk_i) begin
        osc_div <= osc_div + 3'h1;
        lf_osc <= osc_div[2];
    end

    wdps_top u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .period_select_cfg_i(cfg_ps),
        .clock_source_cfg_i(3'h0),
        .operating_mode_cfg_i(cfg_mode),
        .low_freq_internal_osc_i(lf_osc),
        .mid_freq_internal_osc_i(1'b0),
        .secondary_osc_i(1'b0),
        .sleep_i(sleep),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(dat),
        .wb_ack_o(ack),
        .wb_dat_o(rdat),
        .irq_o(irq),
        .wdog_timeout_o(tmo),
        .period_select_run_o(run)
    );

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; request held until ack is sampled high.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        // A missing answer ends the run in the closing report.
        if (ack !== 1'b1) begin
            error_cnt++;
            $display("ERROR bus ack never came");
            close_out();
        end else begin
            r = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
            sel <= 4'h0;
        end
    endtask

    // Power-on reset with new configuration; capture settles before return.
    task automatic por(input logic [4:0] c, input logic [1:0] m);
        cfg_ps <= c;
        cfg_mode <= m;
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic wait_tmo(input int lim);
        n = 0;
        while (tmo !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    function automatic logic [4:0] dec(input logic [4:0] c);
        if (c <= 5'h12) begin
            return c;
        end
        return (c == 5'h1f) ? 5'h0b : 5'h13;
    endfunction

    initial begin
        logic [4:0] codes [6] = '{5'h00, 5'h12, 5'h13, 5'h14, 5'h1e, 5'h1f};
        // Each class of period code; the blank code comes last on purpose.
        foreach (codes[k]) begin
            por(codes[k], 2'h0);
            chk("run", {27'h0, run}, {27'h0, dec(codes[k])});
            xfer(wdps_pkg::ADR_STATUS, 1'b0, 32'h0, q);
            chk("status", {26'h0, q[5:0]}, {26'h0, codes[k] == 5'h1f, dec(codes[k])});
        end
        xfer(wdps_pkg::ADR_CTRL, 1'b1, 32'h6, q);
        repeat (2) @(posedge clk_i);
        chk("sw period", {27'h0, run}, 32'h3);
        // Locked period: the write is ignored and raises the refusal flag.
        por(5'h05, 2'h0);
        xfer(wdps_pkg::ADR_CTRL, 1'b1, 32'h0, q);
        xfer(wdps_pkg::ADR_IRQ_STAT, 1'b0, 32'h0, q);
        chk("refused", q, 32'h2);
        xfer(wdps_pkg::ADR_IRQ_MASK, 1'b1, 32'h2, q);
        repeat (2) @(posedge clk_i);
        chk("irq set", {31'h0, irq}, 32'h1);
        xfer(wdps_pkg::ADR_IRQ_STAT, 1'b1, 32'h2, q);
        repeat (2) @(posedge clk_i);
        chk("irq clr", {31'h0, irq}, 32'h0);
        chk("locked", {27'h0, run}, 32'h5);
        xfer(8'h40, 1'b0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        // Code 0 times out after 32 reference ticks, some 256 bus cycles.
        sleep <= 1'b1;
        por(5'h00, 2'h3);
        wait_tmo(400);
        chk("always on", {31'h0, n inside {[230:275]}}, 32'h1);
        por(5'h00, 2'h0);
        wait_tmo(400);
        chk("off", 32'(n), 32'd400);
        por(5'h00, 2'h1);
        wait_tmo(400);
        chk("sw off", 32'(n), 32'd400);
        xfer(wdps_pkg::ADR_CTRL, 1'b1, 32'h1, q);
        wait_tmo(400);
        chk("sw on", {31'h0, n inside {[230:275]}}, 32'h1);
        // Awake-only mode must stay suspended while the device sleeps.
        por(5'h00, 2'h2);
        wait_tmo(400);
        chk("asleep", 32'(n), 32'd400);
        close_out();
    end
endmodule // wdps_top_test
